// file: phy_enable_pkg.sv
package phy_enable_pkg;

  // reversible ports with an orientation A and an orientation B phy each
  localparam int TC_PORTS = 2;
  // per-port attach inputs, the last one feeds a single non-reversible phy
  localparam int ATTACH_W = 3;
  // all synchronised inputs: mode, polarity, b attach, a attach, orientation, attach
  localparam int SYNC_W = 11;
  // level after reset of the synchronised inputs, matches the pin pull-downs
  localparam logic [10:0] SYNC_RESET = 11'h000;

  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // control: phy allow mask, bits a[1:0], b[3:2], legacy[4]
  localparam int ALLOW_W = 5;
  localparam logic [4:0] ALLOW_RESET = 5'h1f;

  // status field positions
  localparam int ST_EN_A_POS = 0;
  localparam int ST_EN_B_POS = 2;
  localparam int ST_EN_L_POS = 4;
  localparam int ST_SYNC_POS = 8;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : phy_enable_pkg

// file: level_sync2.sv
`timescale 1ns/10ps
module level_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // two-stage synchroniser; the first stage is seen by the second stage only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : level_sync2

// file: reversible_port_phy_enable.sv
// Summary of operation
// - in mode 2 an asserted orientation-B attach enables that port's B phy
// - with no attach asserted the associated phy stays disabled to save power
// - orientation-A/B attach inputs act only in mode 2, replacing mode-1 inputs
// - polarity select low: attach and orientation inputs are active high
// - polarity select high: attach and orientation inputs are active low
// - polarity select defaults low (pull-down) so inputs read active high
// - mode select low gives mode 1, using attach and orientation inputs only
// - mode select high gives mode 2, using orientation-A/B attach inputs only
// - mode select defaults low (pull-down) so an open pin gives mode 1
// - mode 1: asserted attach enables the port phy, deasserted disables it
// - mode 1: orientation asserted picks phy A, else phy B, only while attached
// - mode 2: asserted orientation-A attach enables the A phy, else off
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module reversible_port_phy_enable
  import phy_enable_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [phy_enable_pkg::ATTACH_W-1:0] ATTACH_IN,
  input wire logic [phy_enable_pkg::TC_PORTS-1:0] ORIENTATION_SEL_IN,
  input wire logic [phy_enable_pkg::TC_PORTS-1:0] ORIENT_A_ATTACH_IN,
  input wire logic [phy_enable_pkg::TC_PORTS-1:0] ORIENT_B_ATTACH_IN,
  input wire logic ATTACH_POLARITY_SEL,
  input wire logic CONTROL_MODE_SEL,
  output logic [phy_enable_pkg::TC_PORTS-1:0] PHY_A_EN,
  output logic [phy_enable_pkg::TC_PORTS-1:0] PHY_B_EN,
  output logic PHY_LEGACY_EN,
  input wire logic [phy_enable_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [phy_enable_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import phy_enable_pkg::*;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_s;
  logic mode_s;
  logic pol_s;
  logic [ATTACH_W-1:0] attach_act;
  logic [TC_PORTS-1:0] orient_act;
  logic [TC_PORTS-1:0] a_att_act;
  logic [TC_PORTS-1:0] b_att_act;
  logic [2:0] orient_w;
  logic [2:0] a_att_w;
  logic [2:0] b_att_w;
  logic [TC_PORTS-1:0] en_a_d;
  logic [TC_PORTS-1:0] en_b_d;
  logic en_l_d;
  logic [ALLOW_W-1:0] allow_q;
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic do_write;

  // turn a pin level into "asserted": polarity high inverts every attach and orientation input
  function automatic logic [2:0] active_level(input logic [2:0] raw, input logic pol);
    active_level = pol ? ~raw : raw;
  endfunction : active_level

  // every control pin crosses into the core clock before use
  assign raw_in = {CONTROL_MODE_SEL, ATTACH_POLARITY_SEL, ORIENT_B_ATTACH_IN,
                   ORIENT_A_ATTACH_IN, ORIENTATION_SEL_IN, ATTACH_IN};

  // reset value zero stands in for the pull-downs: mode 1, active high
  level_sync2 #(
    .W(SYNC_W),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .clk(MCLK),
    .rst(RST),
    .d(raw_in),
    .q(sync_s)
  );

  assign mode_s = sync_s[10];
  assign pol_s = sync_s[9];
  assign attach_act = active_level(sync_s[2:0], pol_s);
  // two-bit groups go through the three-bit helper padded, then the pad bit is dropped
  assign orient_w = active_level({1'b0, sync_s[4:3]}, pol_s);
  assign a_att_w = active_level({1'b0, sync_s[6:5]}, pol_s);
  assign b_att_w = active_level({1'b0, sync_s[8:7]}, pol_s);
  assign orient_act = orient_w[1:0];
  assign a_att_act = a_att_w[1:0];
  assign b_att_act = b_att_w[1:0];

  // enable decode; the inputs of the mode not selected are ignored
  always_comb
  begin
    if (mode_s)
    begin
      en_a_d = a_att_act;
      en_b_d = b_att_act;
      en_l_d = 1'b0;
    end
    else
    begin
      // orientation only matters while the port is attached
      en_a_d = attach_act[1:0] & orient_act;
      en_b_d = attach_act[1:0] & ~orient_act;
      en_l_d = attach_act[2];
    end
  end

  // enables registered and gated by the software allow mask
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      PHY_A_EN <= '0;
      PHY_B_EN <= '0;
      PHY_LEGACY_EN <= 1'b0;
    end
    else
    begin
      PHY_A_EN <= en_a_d & allow_q[1:0];
      PHY_B_EN <= en_b_d & allow_q[3:2];
      PHY_LEGACY_EN <= en_l_d & allow_q[4];
    end
  end

  assign aw_hs = AWVALID & AWREADY;
  assign w_hs = WVALID & WREADY;
  assign b_hs = BVALID & BREADY;
  assign ar_hs = ARVALID & ARREADY;
  assign do_write = aw_held_q & w_held_q & ~BVALID;

  // address and data are latched independently, so either may come first
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= AWADDR;
      end
      else if (b_hs)
        aw_held_q <= 1'b0;
      if (w_hs)
      begin
        w_held_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      else if (b_hs)
        w_held_q <= 1'b0;
      // ready drops right after a handshake until the response is taken
      AWREADY <= ~(aw_hs | (aw_held_q & ~b_hs));
      WREADY <= ~(w_hs | (w_held_q & ~b_hs));
    end
  end

  // write commit and response; only the low byte lane carries the mask
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      allow_q <= ALLOW_RESET;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else if (do_write)
    begin
      BVALID <= 1'b1;
      if (awaddr_q == CTRL_OFFSET)
      begin
        BRESP <= RESP_OKAY;
        if (wstrb_q[0])
          allow_q <= wdata_q[ALLOW_W-1:0];
      end
      else if (awaddr_q == STATUS_OFFSET)
        BRESP <= RESP_OKAY; // status is read-only, write ignored
      else
        BRESP <= RESP_SLVERR;
    end
    else if (b_hs)
      BVALID <= 1'b0;
  end

  // read channel: one read at a time, answered the cycle after the address
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= RESP_OKAY;
    end
    else
    begin
      ARREADY <= ~(ar_hs | (RVALID & ~RREADY));
      if (ar_hs)
      begin
        RVALID <= 1'b1;
        RDATA <= '0;
        RRESP <= RESP_OKAY;
        if (ARADDR == CTRL_OFFSET)
          RDATA[ALLOW_W-1:0] <= allow_q;
        else if (ARADDR == STATUS_OFFSET)
        begin
          RDATA[ST_EN_A_POS +: TC_PORTS] <= PHY_A_EN;
          RDATA[ST_EN_B_POS +: TC_PORTS] <= PHY_B_EN;
          RDATA[ST_EN_L_POS] <= PHY_LEGACY_EN;
          RDATA[ST_SYNC_POS +: SYNC_W] <= sync_s;
        end
        else
          RRESP <= RESP_SLVERR;
      end
      else if (RVALID & RREADY)
        RVALID <= 1'b0;
    end
  end

  a_mode2_b_follow: assert property (@(posedge MCLK) disable iff (RST)
    (mode_s && allow_q[3:2] == 2'b11) |=> (PHY_B_EN == $past(b_att_act)))
    else $error("mode 2 b phy enable does not follow b attach");

  a_idle_port_off: assert property (@(posedge MCLK) disable iff (RST)
    (!mode_s && !attach_act[0]) |=> (!PHY_A_EN[0] && !PHY_B_EN[0]))
    else $error("phy enabled with no attach");

  a_mode1_ignores_mux: assert property (@(posedge MCLK) disable iff (RST)
    (!mode_s && allow_q[1:0] == 2'b11) |=> (PHY_A_EN == $past(attach_act[1:0] & orient_act)))
    else $error("mode 1 a phy enable not from attach and orientation");

  a_active_high_attach: assert property (@(posedge MCLK) disable iff (RST)
    (!pol_s && !mode_s && sync_s[2] && allow_q[4]) |=> PHY_LEGACY_EN)
    else $error("active-high attach did not enable phy");

  a_active_low_attach: assert property (@(posedge MCLK) disable iff (RST)
    (pol_s && !mode_s && !sync_s[2] && allow_q[4]) |=> PHY_LEGACY_EN)
    else $error("active-low attach did not enable phy");

  a_pulldown_default: assert property (@(posedge MCLK) disable iff (RST)
    $past(RST) |-> (!pol_s && !mode_s))
    else $error("polarity or mode not at pulled-down level after reset");

  a_mode2_no_legacy: assert property (@(posedge MCLK) disable iff (RST)
    mode_s |=> !PHY_LEGACY_EN)
    else $error("mode 1 attach used in mode 2");

  a_orient_pick: assert property (@(posedge MCLK) disable iff (RST)
    (!mode_s && attach_act[0] && !orient_act[0] && allow_q[2])
      |=> (PHY_B_EN[0] && !PHY_A_EN[0]))
    else $error("orientation deasserted did not pick phy b");

  a_mode2_a_enable: assert property (@(posedge MCLK) disable iff (RST)
    (mode_s && a_att_act[1] && allow_q[1]) |=> PHY_A_EN[1])
    else $error("mode 2 a attach did not enable a phy");

  a_sync_latency: assert property (@(posedge MCLK) disable iff (RST)
    (!$past(RST) && !$past(RST, 2)) |-> (sync_s == $past(raw_in, 2)))
    else $error("inputs not seen through two synchroniser stages");

  a_reset_phy_off: assert property (@(posedge MCLK) disable iff (RST)
    $past(RST) |-> (PHY_A_EN == '0 && PHY_B_EN == '0 && !PHY_LEGACY_EN))
    else $error("phy enabled straight after reset");

endmodule : reversible_port_phy_enable

// file: attach_ctrl_model.sv
`timescale 1ns/10ps
// stand-in for the external attach/orientation controller, driven with logical levels
module attach_ctrl_model
  import phy_enable_pkg::*;
(
  input wire logic pol,
  input wire logic mode,
  input wire logic [phy_enable_pkg::ATTACH_W-1:0] att,
  input wire logic [phy_enable_pkg::TC_PORTS-1:0] ori,
  input wire logic [phy_enable_pkg::TC_PORTS-1:0] a_att,
  input wire logic [phy_enable_pkg::TC_PORTS-1:0] b_att,
  output logic pol_pin,
  output logic mode_pin,
  output logic [phy_enable_pkg::ATTACH_W-1:0] att_pin,
  output logic [phy_enable_pkg::TC_PORTS-1:0] ori_pin,
  output logic [phy_enable_pkg::TC_PORTS-1:0] a_pin,
  output logic [phy_enable_pkg::TC_PORTS-1:0] b_pin
);
  import phy_enable_pkg::*;

  // strapped levels; mode-2 pins stay driven in mode 1 so the hub must ignore them
  assign pol_pin = pol;
  assign mode_pin = mode;
  // asserted means 1 when strapped active high, 0 when active low
  assign att_pin = pol ? ~att : att;
  assign ori_pin = pol ? ~ori : ori;
  assign a_pin = pol ? ~a_att : a_att;
  assign b_pin = pol ? ~b_att : b_att;
endmodule : attach_ctrl_model

// file: reversible_port_phy_enable_tb_top.sv
`timescale 1ns/10ps
module reversible_port_phy_enable_tb_top;
  import phy_enable_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic pol = 1'h0;
  logic mode = 1'h0;
  logic [2:0] att = 3'h0;
  logic [1:0] ori = 2'h0, aa = 2'h0, ba = 2'h0;
  logic pol_p, mode_p, l_en;
  logic [2:0] att_p;
  logic [1:0] ori_p, aa_p, ba_p, a_en, b_en, bresp, rresp, r;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [4:0] mask = 5'h1f;
  int n_fail = 0;
  int comparisons = 0;

  // free-running core clock, 100 ns period
  always #50 mclk = ~mclk;

  attach_ctrl_model i_far (.pol(pol), .mode(mode), .att(att), .ori(ori), .a_att(aa),
    .b_att(ba), .pol_pin(pol_p), .mode_pin(mode_p), .att_pin(att_p), .ori_pin(ori_p),
    .a_pin(aa_p), .b_pin(ba_p));

  reversible_port_phy_enable i_dut (.MCLK(mclk), .RST(rst), .ATTACH_IN(att_p),
    .ORIENTATION_SEL_IN(ori_p), .ORIENT_A_ATTACH_IN(aa_p), .ORIENT_B_ATTACH_IN(ba_p),
    .ATTACH_POLARITY_SEL(pol_p), .CONTROL_MODE_SEL(mode_p), .PHY_A_EN(a_en),
    .PHY_B_EN(b_en), .PHY_LEGACY_EN(l_en), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("failures %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // no local limit: only the watchdog ends a wait for the response
    forever
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask : rd

  // drive logical levels, let two sync stages and the output flop pass, compare
  task automatic set(input logic m, p, input logic [2:0] t, input logic [1:0] o, x, y);
    logic [4:0] e;
    @(posedge mclk);
    mode <= m;
    pol <= p;
    att <= t;
    ori <= o;
    aa <= x;
    ba <= y;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    e = m ? {1'h0, y, x} : {t[2], t[1:0] & ~o, t[1:0] & o};
    chk({l_en, b_en, a_en}, e & mask);
  endtask : set

  task automatic t_reset();
    @(negedge mclk);
    chk({l_en, b_en, a_en}, 5'h00);
    rd(CTRL_OFFSET, d, r);
    chk(d, 32'h1f);
    chk(r, RESP_OKAY);
    rd(STATUS_OFFSET, d, r);
    chk(d, 32'h0);
  endtask : t_reset

  // every attach/orientation combination, mode-2 pins asserted throughout
  task automatic t_mode1(input logic p);
    for (int k = 0; k < 32; k++)
      set(1'h0, p, k[2:0], k[4:3], 2'h3, 2'h3);
  endtask : t_mode1

  task automatic t_mode2(input logic p);
    for (int k = 0; k < 16; k++)
      set(1'h1, p, 3'h7, k[1:0], k[1:0], k[3:2]);
  endtask : t_mode2

  // the enable must not move before the third edge after the input change
  task automatic t_latency();
    @(posedge mclk);
    att <= 3'h1;
    ori <= 2'h1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(a_en, 2'h0);
    @(negedge mclk);
    chk(a_en, 2'h1);
  endtask : t_latency

  task automatic t_regs();
    wr(CTRL_OFFSET, 32'h5, r);
    chk(r, RESP_OKAY);
    mask = 5'h05;
    set(1'h0, 1'h0, 3'h7, 2'h1, 2'h0, 2'h0);
    rd(STATUS_OFFSET, d, r);
    chk(d, 32'h00000f01);
    wr(8'h10, 32'h0, r);
    chk(r, RESP_SLVERR);
    rd(8'h10, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(STATUS_OFFSET, 32'h0, r);
    chk(r, RESP_OKAY);
    rd(CTRL_OFFSET, d, r);
    chk(d, 32'h5);
    wr(CTRL_OFFSET, 32'h1f, r);
    mask = 5'h1f;
    set(1'h0, 1'h0, 3'h7, 2'h1, 2'h0, 2'h0);
  endtask : t_regs

  // mid-run reset with a port attached: enables drop, then return after the sync delay
  task automatic t_midreset();
    set(1'h0, 1'h0, 3'h7, 2'h1, 2'h0, 2'h0);
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(negedge mclk);
    chk({l_en, b_en, a_en}, 5'h00);
    @(negedge mclk);
    chk({l_en, b_en, a_en}, 5'h00);
    @(negedge mclk);
    chk({l_en, b_en, a_en}, 5'h00);
    @(negedge mclk);
    chk({l_en, b_en, a_en}, 5'h19);
  endtask : t_midreset

  // main sequence
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
    t_mode1(1'h0);
    t_mode1(1'h1);
    t_mode2(1'h0);
    t_mode2(1'h1);
    set(1'h0, 1'h0, 3'h0, 2'h0, 2'h0, 2'h0);
    t_latency();
    t_regs();
    t_midreset();
    complete_run();
  end

  // watchdog, well beyond the roughly 450 cycles the sequence needs
  initial
  begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule : reversible_port_phy_enable_tb_top
